// file: verilog/pxm_map.vh
`ifndef PXM_MAP_VH
`define PXM_MAP_VH
// ****************************************
// Register addresses
// ****************************************
`define PXM_ADDR_ROUTE0   8'hE1
`define PXM_ADDR_ROUTE1   8'hE2
`define PXM_ADDR_MASK0    8'hFE
`define PXM_ADDR_P0EXP    8'hFD
`define PXM_ADDR_MASK1    8'hEE
`define PXM_ADDR_P1EXP    8'hED
// ****************************************
// Reset values
// ****************************************
`define PXM_RST_ROUTE0    8'h00
`define PXM_RST_ROUTE1    8'h00
`define PXM_RST_MASK      8'h00
`define PXM_RST_EXP       8'hFF
// ****************************************
// Route register 0 fields
// ****************************************
`define PXM_R0_EEPUP      7
`define PXM_R0_SMB1       6
`define PXM_R0_CMPA       5
`define PXM_R0_CMP        4
`define PXM_R0_CLK        3
`define PXM_R0_SMB0       2
`define PXM_R0_SPI        1
`define PXM_R0_UART       0
// ****************************************
// Route register 1 fields
// ****************************************
`define PXM_R1_WPUD       7
`define PXM_R1_XBEN       6
`define PXM_R1_T1         5
`define PXM_R1_T0         4
`define PXM_R1_EXTCNT     3
`define PXM_R1_UNUSED     2
`define PXM_R1_CH_HI      1
`define PXM_R1_CH_LO      0
`define PXM_R1_WMASK      8'hFB
`endif

// file: verilog/pxm_sync.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Three-stage pin synchroniser, 8 bits
// ****************************************
module pxm_sync (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [7:0] pin_in,
  output reg  [7:0] level_out
);
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  reg [7:0] s3_q;

  // Level changes only once stages two and three agree
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      s1_q      <= 8'h00;
      s2_q      <= 8'h00;
      s3_q      <= 8'h00;
      level_out <= 8'h00;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_out <= (s2_q & s3_q) | (level_out & (s2_q | s3_q));
    end
  end
endmodule // pxm_sync
`default_nettype wire

// file: verilog/pxm_match.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Masked compare of one port
// ****************************************
module pxm_match (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [7:0] level_in,
  input  wire [7:0] mask_in,
  input  wire [7:0] expect_in,
  output reg        miss_out
);
  // Registered so the main module output stays a flop
  always @(posedge ref_clk_in) begin
    if (!nrst_in)
      miss_out <= 1'b0;
    else
      miss_out <= |((level_in ^ expect_in) & mask_in);
  end
endmodule // pxm_match
`default_nettype wire

// file: verilog/pxm_crossbar.v
//
// Behaviour
// - Strong pullups on P2.2, P2.3 when set
// - Second SMBus reaches pins only when set
// - Async comparator output routed when set
// - Sync comparator output routed when set
// - Inverted system clock routed when set
// - First SMBus data and clock routed
// - SPI routed, three or four pins
// - UART fixed on P0.4 and P0.5
// - Weak pullups on unless disabled
// - Timer 1 input routed when set
// - Timer 0 input routed when set
// - Counter external count input routed
// - Unused bit reads zero, ignores writes
// - Channel field routes zero to three channels
// - Masked port levels differ gives mismatch
// - Compare uses real pin levels always
// - Mismatch usable for interrupt and wake
// - Mask zero excludes pin from compare
// - Expected bit selects low or high; resets ones
// - Crossbar off keeps drivers off
`timescale 1ns/1ps
`default_nettype none
`include "pxm_map.vh"
module pxm_crossbar (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire       sfr_rd_in,
  input  wire [7:0] sfr_wdata_in,
  output reg  [7:0] sfr_rdata_out,
  input  wire [7:0] port0_pin_in,
  input  wire [7:0] port1_pin_in,
  input  wire       spi_four_wire_in,
  output reg        crossbar_enable_out,
  output reg        eeprom_strong_pullup_en_out,
  output reg        weak_pullup_en_out,
  output reg        uart_route_en_out,
  output reg        spi_route_en_out,
  output reg  [2:0] spi_pin_count_out,
  output reg        first_smbus_route_en_out,
  output reg        inv_clock_out_route_en_out,
  output reg        cmp_out_route_en_out,
  output reg        cmp_async_out_route_en_out,
  output reg        second_smbus_route_en_out,
  output reg        timer0_input_route_en_out,
  output reg        timer1_input_route_en_out,
  output reg        ext_count_input_route_en_out,
  output reg  [2:0] counter_channel_en_out,
  output reg        port_mismatch_out
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] route0_q;
  reg  [7:0] route1_q;
  reg  [7:0] port0_compare_mask_q;
  reg  [7:0] port1_compare_mask_q;
  reg  [7:0] p0exp_q;
  reg  [7:0] p1exp_q;
  wire [7:0] p0_lvl;
  wire [7:0] p1_lvl;
  wire       p0_miss;
  wire       p1_miss;
  wire       xb_on;

  // Channel field to per-channel enables
  function [2:0] chan_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'b01:   chan_decode = 3'b001;
        2'b10:   chan_decode = 3'b011;
        2'b11:   chan_decode = 3'b111;
        default: chan_decode = 3'b000;
      endcase
    end
  endfunction

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      route0_q <= `PXM_RST_ROUTE0;
      route1_q <= `PXM_RST_ROUTE1;
      port0_compare_mask_q <= `PXM_RST_MASK;
      port1_compare_mask_q <= `PXM_RST_MASK;
      p0exp_q  <= `PXM_RST_EXP;
      p1exp_q  <= `PXM_RST_EXP;
    end else if (sfr_wr_in) begin
      case (sfr_addr_in)
        `PXM_ADDR_ROUTE0: route0_q <= sfr_wdata_in;
        `PXM_ADDR_ROUTE1: route1_q <= sfr_wdata_in & `PXM_R1_WMASK;
        `PXM_ADDR_MASK0:  port0_compare_mask_q <= sfr_wdata_in;
        `PXM_ADDR_MASK1:  port1_compare_mask_q <= sfr_wdata_in;
        `PXM_ADDR_P0EXP:  p0exp_q  <= sfr_wdata_in;
        `PXM_ADDR_P1EXP:  p1exp_q  <= sfr_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Read data registered; unmapped addresses answer zero
  always @(posedge ref_clk_in) begin
    if (!nrst_in)
      sfr_rdata_out <= 8'h00;
    else if (sfr_rd_in) begin
      case (sfr_addr_in)
        `PXM_ADDR_ROUTE0: sfr_rdata_out <= route0_q;
        `PXM_ADDR_ROUTE1: sfr_rdata_out <= route1_q & `PXM_R1_WMASK;
        `PXM_ADDR_MASK0:  sfr_rdata_out <= port0_compare_mask_q;
        `PXM_ADDR_MASK1:  sfr_rdata_out <= port1_compare_mask_q;
        `PXM_ADDR_P0EXP:  sfr_rdata_out <= p0exp_q;
        `PXM_ADDR_P1EXP:  sfr_rdata_out <= p1exp_q;
        default:          sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Routing enables
  // ****************************************
  assign xb_on = route1_q[`PXM_R1_XBEN];

  // Every route except the two pullup enables gated by the crossbar enable so no driver turns on early
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      crossbar_enable_out          <= 1'b0;
      eeprom_strong_pullup_en_out  <= 1'b0;
      weak_pullup_en_out           <= 1'b0;
      uart_route_en_out            <= 1'b0;
      spi_route_en_out             <= 1'b0;
      spi_pin_count_out            <= 3'd0;
      first_smbus_route_en_out     <= 1'b0;
      inv_clock_out_route_en_out   <= 1'b0;
      cmp_out_route_en_out         <= 1'b0;
      cmp_async_out_route_en_out   <= 1'b0;
      second_smbus_route_en_out    <= 1'b0;
      timer0_input_route_en_out    <= 1'b0;
      timer1_input_route_en_out    <= 1'b0;
      ext_count_input_route_en_out <= 1'b0;
      counter_channel_en_out       <= 3'b000;
    end else begin
      crossbar_enable_out          <= xb_on;
      eeprom_strong_pullup_en_out  <= route0_q[`PXM_R0_EEPUP];
      weak_pullup_en_out           <= ~route1_q[`PXM_R1_WPUD];
      uart_route_en_out            <= xb_on & route0_q[`PXM_R0_UART];
      spi_route_en_out             <= xb_on & route0_q[`PXM_R0_SPI];
      spi_pin_count_out            <= (xb_on & route0_q[`PXM_R0_SPI]) ?
                                      (spi_four_wire_in ? 3'd4 : 3'd3) : 3'd0;
      first_smbus_route_en_out     <= xb_on & route0_q[`PXM_R0_SMB0];
      inv_clock_out_route_en_out   <= xb_on & route0_q[`PXM_R0_CLK];
      cmp_out_route_en_out         <= xb_on & route0_q[`PXM_R0_CMP];
      cmp_async_out_route_en_out   <= xb_on & route0_q[`PXM_R0_CMPA];
      second_smbus_route_en_out    <= xb_on & route0_q[`PXM_R0_SMB1];
      timer0_input_route_en_out    <= xb_on & route1_q[`PXM_R1_T0];
      timer1_input_route_en_out    <= xb_on & route1_q[`PXM_R1_T1];
      ext_count_input_route_en_out <= xb_on & route1_q[`PXM_R1_EXTCNT];
      counter_channel_en_out       <= xb_on ?
        chan_decode(route1_q[`PXM_R1_CH_HI:`PXM_R1_CH_LO]) : 3'b000;
    end
  end

  // ****************************************
  // Port match
  // ****************************************
  // Raw pins, not the routed view, feed the compare
  pxm_sync u_sync0 (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .pin_in     (port0_pin_in),
    .level_out  (p0_lvl)
  );
  pxm_sync u_sync1 (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .pin_in     (port1_pin_in),
    .level_out  (p1_lvl)
  );
  pxm_match u_m0 (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .level_in   (p0_lvl),
    .mask_in    (port0_compare_mask_q),
    .expect_in  (p0exp_q),
    .miss_out   (p0_miss)
  );
  pxm_match u_m1 (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .level_in   (p1_lvl),
    .mask_in    (port1_compare_mask_q),
    .expect_in  (p1exp_q),
    .miss_out   (p1_miss)
  );

  // Level, not sticky: interrupt and wake logic latch it themselves
  always @(posedge ref_clk_in) begin
    if (!nrst_in)
      port_mismatch_out <= 1'b0;
    else
      port_mismatch_out <= p0_miss | p1_miss;
  end
endmodule // pxm_crossbar
`default_nettype wire

// file: verification/pxm_crossbar_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module pxm_crossbar_asserts (
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       crossbar_enable_out,
  input wire logic       eeprom_strong_pullup_en_out,
  input wire logic       weak_pullup_en_out,
  input wire logic       uart_route_en_out,
  input wire logic       spi_route_en_out,
  input wire logic [2:0] spi_pin_count_out,
  input wire logic       timer0_input_route_en_out,
  input wire logic [2:0] counter_channel_en_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_xben;
    (sfr_wr_in && sfr_addr_in == 8'hE2) |-> ##2 crossbar_enable_out == $past(sfr_wdata_in[6], 2);
  endproperty
  a_xben: assert property (p_xben) else $error("crossbar enable wrong");
  property p_uart;
    (sfr_wr_in && sfr_addr_in == 8'hE1) |->
      ##2 uart_route_en_out == ($past(sfr_wdata_in[0], 2) && crossbar_enable_out);
  endproperty
  a_uart: assert property (p_uart) else $error("uart route wrong");
  property p_eep;
    (sfr_wr_in && sfr_addr_in == 8'hE1) |-> ##2 eeprom_strong_pullup_en_out == $past(sfr_wdata_in[7], 2);
  endproperty
  a_eep: assert property (p_eep) else $error("strong pullup wrong");
  property p_weak;
    (sfr_wr_in && sfr_addr_in == 8'hE2) |-> ##2 weak_pullup_en_out != $past(sfr_wdata_in[7], 2);
  endproperty
  a_weak: assert property (p_weak) else $error("weak pullup wrong");
  property p_gate;
    !crossbar_enable_out |-> !(uart_route_en_out || spi_route_en_out || timer0_input_route_en_out
      || counter_channel_en_out != 3'h0);
  endproperty
  a_gate: assert property (p_gate) else $error("route while crossbar off");
  property p_spi;
    spi_route_en_out ? (spi_pin_count_out == 3'h3 || spi_pin_count_out == 3'h4) : spi_pin_count_out == 3'h0;
  endproperty
  a_spi: assert property (p_spi) else $error("spi pin count wrong");
  property p_chan;
    counter_channel_en_out inside {3'h0, 3'h1, 3'h3, 3'h7};
  endproperty
  a_chan: assert property (p_chan) else $error("channel set wrong");
  property p_unused;
    (sfr_rd_in && sfr_addr_in == 8'hE2) |=> !sfr_rdata_out[2];
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit reads one");
endmodule // pxm_crossbar_asserts
bind pxm_crossbar pxm_crossbar_asserts u_pxm_crossbar_asserts (.ref_clk_in, .nrst_in, .sfr_addr_in,
  .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .crossbar_enable_out,
  .eeprom_strong_pullup_en_out, .weak_pullup_en_out, .uart_route_en_out, .spi_route_en_out,
  .spi_pin_count_out, .timer0_input_route_en_out, .counter_channel_en_out);
`default_nettype wire

// file: verification/pxm_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port pin model
// ****************************************
module pxm_pins (
  input  wire logic       ref_clk_in,
  input  wire logic       drive_en_in,
  input  wire logic       weak_pullup_en_in,
  input  wire logic [7:0] level0_in,
  input  wire logic [7:0] level1_in,
  output var  logic [7:0] port0_pin_out,
  output var  logic [7:0] port1_pin_out
);
  logic [7:0] float_q = 8'h55;
  always @(posedge ref_clk_in) float_q <= ~float_q;
  // Released pins never keep their last level, so stale data cannot pass
  always_comb begin
    port0_pin_out = drive_en_in ? level0_in : (weak_pullup_en_in ? 8'hFF : float_q);
    port1_pin_out = drive_en_in ? level1_in : (weak_pullup_en_in ? 8'hFF : float_q);
  end
endmodule // pxm_pins
`default_nettype wire

// file: verification/test_pxm_crossbar.sv
`timescale 1ns/1ps
`default_nettype none
`include "pxm_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************
// Bench
// ****************************************
module test_pxm_crossbar;
  logic       ref_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       sfr_wr_in = 1'b0;
  logic       sfr_rd_in = 1'b0;
  logic       four = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] lvl0 = 8'hFF;
  logic [7:0] lvl1 = 8'hFF;
  logic [7:0] rdata, p0, p1;
  logic [6:0] r0v;
  logic [2:0] r1v, chan, spic;
  logic       xben, eep, wpu, mis;
  logic [2:0] tbl [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  int         miscompares = 0;
  int         checked = 0;
  int         cycles = 0;
  pxm_pins u_pxm_pins (.ref_clk_in(ref_clk_in), .drive_en_in(1'b1), .weak_pullup_en_in(wpu),
    .level0_in(lvl0), .level1_in(lvl1), .port0_pin_out(p0), .port1_pin_out(p1));
  pxm_crossbar u_pxm_crossbar (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(rdata),
    .port0_pin_in(p0), .port1_pin_in(p1), .spi_four_wire_in(four), .crossbar_enable_out(xben),
    .eeprom_strong_pullup_en_out(eep), .weak_pullup_en_out(wpu), .uart_route_en_out(r0v[0]),
    .spi_route_en_out(r0v[1]), .spi_pin_count_out(spic), .first_smbus_route_en_out(r0v[2]),
    .inv_clock_out_route_en_out(r0v[3]), .cmp_out_route_en_out(r0v[4]),
    .cmp_async_out_route_en_out(r0v[5]), .second_smbus_route_en_out(r0v[6]),
    .timer0_input_route_en_out(r1v[1]), .timer1_input_route_en_out(r1v[2]),
    .ext_count_input_route_en_out(r1v[0]), .counter_channel_en_out(chan), .port_mismatch_out(mis));
  always #10 ref_clk_in = ~ref_clk_in;
  // Whole run is under 400 cycles; the ceiling only catches a hang
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  task complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // Second edge lets route outputs settle and spaces strobes apart
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    cyc(1);
    sfr_wr_in = 1'b0;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    cyc(1);
    sfr_rd_in = 1'b0;
    `CHK(rdata, e)
    cyc(1);
  endtask
  initial begin
    cyc(3);
    nrst_in = 1'b1;
    rd(`PXM_ADDR_ROUTE0, 8'h00);
    rd(`PXM_ADDR_ROUTE1, 8'h00);
    rd(`PXM_ADDR_MASK0, 8'h00);
    rd(`PXM_ADDR_P0EXP, 8'hFF);
    rd(`PXM_ADDR_MASK1, 8'h00);
    rd(`PXM_ADDR_P1EXP, 8'hFF);
    rd(8'h80, 8'h00);
    `CHK(wpu, 1'b1)
    $display("reset test done");
    wr(`PXM_ADDR_ROUTE0, 8'hFF);
    `CHK({xben, r0v, r1v}, 11'h000)
    `CHK(eep, 1'b1)
    wr(`PXM_ADDR_ROUTE1, 8'h7F);
    rd(`PXM_ADDR_ROUTE1, 8'h7B);
    `CHK(r0v, 7'h7F)
    `CHK(r1v, 3'h7)
    `CHK(spic, 3'h4)
    four = 1'b0;
    cyc(3);
    `CHK(spic, 3'h3)
    for (int i = 0; i < 4; i++) begin
      wr(`PXM_ADDR_ROUTE1, 8'hC0 | 8'(i));
      `CHK(chan, tbl[i])
      `CHK(wpu, 1'b0)
    end
    wr(`PXM_ADDR_ROUTE0, 8'h00);
    `CHK({eep, r0v}, 8'h00)
    $display("route test done");
    lvl0 = 8'h00;
    cyc(8);
    `CHK(mis, 1'b0)
    wr(`PXM_ADDR_MASK0, 8'h01);
    cyc(6);
    `CHK(mis, 1'b1)
    wr(`PXM_ADDR_P0EXP, 8'hFE);
    cyc(6);
    `CHK(mis, 1'b0)
    lvl0 = 8'h80;
    cyc(8);
    `CHK(mis, 1'b0)
    lvl0 = 8'h01;
    cyc(8);
    `CHK(mis, 1'b1)
    cyc(20);
    `CHK(mis, 1'b1)
    lvl0 = 8'h00;
    wr(`PXM_ADDR_MASK1, 8'h80);
    wr(`PXM_ADDR_P1EXP, 8'h00);
    cyc(8);
    `CHK(mis, 1'b1)
    lvl1 = 8'h7F;
    cyc(8);
    `CHK(mis, 1'b0)
    $display("match test done");
    complete_run;
  end
endmodule // test_pxm_crossbar
`default_nettype wire
